/* pcv_pkg.sv */
/*
  Constants and carrier types for the parallel component video source.
  Assumes a single system clock domain; the link word clock is sampled.
*/
package pcv_pkg;

  // ==========================================================
  // Word bus layout
  localparam int          WORD_W     = 10;
  localparam int          NARROW_W   = 8;
  localparam int          NARROW_LSB = 2;
  localparam logic [1:0]  NARROW_PAD = 2'h0;

  // ==========================================================
  // Sample phases within one pixel pair
  localparam logic [1:0]  PH_CB      = 2'h0;
  localparam logic [1:0]  PH_Y0      = 2'h1;
  localparam logic [1:0]  PH_CR      = 2'h2;
  localparam logic [1:0]  PH_Y1      = 2'h3;
  localparam logic [1:0]  PH_STEP    = 2'h1;

  // ==========================================================
  // Filler values sent when nothing else is due
  localparam logic [9:0]  FILL_CHROMA = 10'h200;
  localparam logic [9:0]  FILL_LUMA   = 10'h040;

  // ==========================================================
  // Reset values
  localparam logic [9:0]  WORD_RST   = 10'h000;
  localparam logic [2:0]  SYNC_RST   = 3'h0;

  typedef logic [WORD_W-1:0] pcv_word_t;

  typedef struct packed {
    pcv_word_t cb;
    pcv_word_t y0;
    pcv_word_t cr;
    pcv_word_t y1;
  } pcv_pair_t;

  localparam pcv_pair_t FILL_PAIR =
    '{cb: FILL_CHROMA, y0: FILL_LUMA, cr: FILL_CHROMA, y1: FILL_LUMA};

  typedef enum logic {
    LS_BLANK,
    LS_ACTIVE
  } pcv_line_t;

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
  } pcv_sync_t;

  typedef struct packed {
    pcv_line_t  line;
    logic [1:0] phase;
    pcv_pair_t  pair;
    logic       narrow;
    pcv_word_t  word_t;
    pcv_word_t  word_c;
    logic       clk_t;
    logic       clk_c;
    logic       pair_take;
    logic       anc_take;
    logic       underrun;
  } pcv_src_t;

endpackage : pcv_pkg

/* pcv_edge_sync.sv */
/*
  Three-stage sampler for the link word clock, with edge pulses.
  Assumes the input is asynchronous to i_clk and much slower than it.
*/
`timescale 1ns/10ps
module pcv_edge_sync
  import pcv_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_lvl,
  output logic      o_rise,
  output logic      o_fall
);

  pcv_sync_t st_q;
  pcv_sync_t st_d;
  logic      agree;

  // ==========================================================
  // Filter: a change counts once stages two and three agree
  always_comb
  begin
    st_d    = st_q;
    st_d.sh = {st_q.sh[1:0], i_lvl};
    agree   = (st_q.sh[1] == st_q.sh[2]);
    if (agree)
    begin
      st_d.lvl = st_q.sh[2];
    end
    o_rise  = agree && st_q.sh[2] && !st_q.lvl;   // R4
    o_fall  = agree && !st_q.sh[2] && st_q.lvl;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= '{sh: SYNC_RST, lvl: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule : pcv_edge_sync

/* pcv_source.sv */
/*
  Source end of a bit-parallel component video link.
  Assumes the word clock arrives on a pin and user logic on I_CLK
  presents pixel pairs, ancillary words and the blanking level.
*/
// What this block does
// (R1) Ten-bit bus; eight-bit words on bits 2-9
// (R2) Lanes carry Cb, Y, Cr, Y repeating
// (R3) Ancillary words only during blanking
// (R4) Word clock accompanies data; rising edge transfers
// (R5) Rising clock edge sits mid-word
// (R6) Real-time unbuffered words, one line per block
// (R7) True terminal high for one, complement low
// (R8) Update words on falling clock edge
`timescale 1ns/10ps
module pcv_source
  import pcv_pkg::*;
(
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_LINK_CLK,
  input  wire logic                I_NARROW,
  input  wire logic                I_BLANK,
  input  wire pcv_pkg::pcv_pair_t  I_PAIR,
  input  wire logic                I_PAIR_VALID,
  input  wire pcv_pkg::pcv_word_t  I_ANC,
  input  wire logic                I_ANC_VALID,
  output pcv_pkg::pcv_word_t       O_DATA_T,
  output pcv_pkg::pcv_word_t       O_DATA_C,
  output logic                     O_CLK_T,
  output logic                     O_CLK_C,
  output logic                     O_PAIR_TAKE,
  output logic                     O_ANC_TAKE,
  output logic                     O_UNDERRUN
);

  pcv_src_t   st_q;
  pcv_src_t   st_d;
  logic       rise;
  logic       fall;
  logic [1:0] ph;
  pcv_word_t  w;

  // ==========================================================
  // Word clock edges
  pcv_edge_sync u_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_lvl   (I_LINK_CLK),
    .o_rise  (rise),
    .o_fall  (fall)
  );

  function automatic pcv_word_t pick(input pcv_pair_t p,
                                     input logic [1:0] sel);
    pcv_word_t r;
    r = p.cb;
    unique case (sel)
      PH_CB: r = p.cb;
      PH_Y0: r = p.y0;
      PH_CR: r = p.cr;
      PH_Y1: r = p.y1;
    endcase
    return r;
  endfunction : pick

  function automatic pcv_word_t lanes(input pcv_word_t v,
                                      input logic nar);
    pcv_word_t r;
    r = v;
    if (nar)
    begin
      r = {v[NARROW_W-1:0], NARROW_PAD};               // R1
    end
    return r;
  endfunction : lanes

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d           = st_q;
    st_d.pair_take = 1'b0;
    st_d.anc_take  = 1'b0;
    st_d.underrun  = 1'b0;
    ph             = 2'(st_q.phase + PH_STEP);          // R2
    w              = FILL_CHROMA;
    if (rise)
    begin
      st_d.clk_t = 1'b1;                                 // R4
      st_d.clk_c = 1'b0;
    end
    // Words only move on the falling edge, so the forwarded rising
    // edge lands half a period later, in the middle of the word.
    if (fall)                                            // R8
    begin
      st_d.clk_t  = 1'b0;                                // R5
      st_d.clk_c  = 1'b1;
      st_d.narrow = I_NARROW;
      if (I_BLANK)
      begin
        st_d.line = LS_BLANK;
        w = pick(FILL_PAIR, ph);
        if (I_ANC_VALID)                                 // R3
        begin
          w             = I_ANC;
          st_d.anc_take = 1'b1;
        end
      end
      else
      begin
        // Each active line starts cleanly on a Cb sample
        if (st_q.line == LS_BLANK)                       // R6
        begin
          ph = PH_CB;
        end
        st_d.line = LS_ACTIVE;
        if (ph == PH_CB)
        begin
          // No buffer: a missing pair is replaced, not waited for
          if (I_PAIR_VALID)                              // R6
          begin
            st_d.pair      = I_PAIR;
            st_d.pair_take = 1'b1;
          end
          else
          begin
            st_d.pair     = FILL_PAIR;
            st_d.underrun = 1'b1;
          end
        end
        w = pick(st_d.pair, ph);                         // R2
      end
      st_d.phase  = ph;
      st_d.word_t = lanes(w, I_NARROW);
      st_d.word_c = ~lanes(w, I_NARROW);                 // R7
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      st_q <= '{line: LS_BLANK, phase: PH_Y1, pair: FILL_PAIR,
                narrow: 1'b0, word_t: WORD_RST, word_c: ~WORD_RST,
                clk_t: 1'b0, clk_c: 1'b1, pair_take: 1'b0,
                anc_take: 1'b0, underrun: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign O_DATA_T    = st_q.word_t;
  assign O_DATA_C    = st_q.word_c;
  assign O_CLK_T     = st_q.clk_t;
  assign O_CLK_C     = st_q.clk_c;
  assign O_PAIR_TAKE = st_q.pair_take;
  assign O_ANC_TAKE  = st_q.anc_take;
  assign O_UNDERRUN  = st_q.underrun;

  // ==========================================================
  // Checks
  default clocking cb_sys @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  narrow_lanes_a: assert property (                      // R1
    st_q.narrow |-> O_DATA_T[NARROW_LSB-1:0] == NARROW_PAD)
    else $error("narrow word leaks into low lanes");

  phase_order_a: assert property (                       // R2
    fall && !I_BLANK && st_q.line == LS_ACTIVE
    |=> st_q.phase == 2'($past(st_q.phase) + PH_STEP))
    else $error("sample phase skipped");

  anc_blank_a: assert property (                         // R3
    O_ANC_TAKE |-> $past(I_BLANK) && O_DATA_T ==
      lanes($past(I_ANC), st_q.narrow))
    else $error("ancillary word outside blanking");

  clk_follow_a: assert property (                        // R4
    rise |=> O_CLK_T ##1 (O_CLK_T || $past(fall)))
    else $error("word clock not forwarded");

  mid_word_a: assert property (                          // R5
    O_CLK_T && $past(O_CLK_T) |-> $stable(O_DATA_T))
    else $error("data moved while clock high");

  line_start_a: assert property (                        // R6
    fall && !I_BLANK && st_q.line == LS_BLANK
    |=> st_q.phase == PH_CB && (O_PAIR_TAKE || O_UNDERRUN))
    else $error("active line not started on Cb");

  complement_a: assert property (                        // R7
    O_DATA_C == ~O_DATA_T && O_CLK_C == !O_CLK_T)
    else $error("pair terminals not complementary");

  fall_update_a: assert property (                       // R8
    !$past(fall) |-> $stable(O_DATA_T))
    else $error("data changed away from falling edge");

  // The slots below are the ones user logic cannot see from the bus,
  // so a refused or replaced word is checked where it is made.
  anc_refused_a: assert property (                       // R3
    fall && !I_BLANK |=> !O_ANC_TAKE)
    else $error("ancillary word taken in active line");

  blank_fill_a: assert property (                        // R3
    fall && I_BLANK && !I_ANC_VALID |=> O_DATA_T ==
      lanes(pick(FILL_PAIR, st_q.phase), st_q.narrow))
    else $error("blanking word not filler");

  pair_slot_a: assert property (                         // R2
    O_PAIR_TAKE || O_UNDERRUN |-> st_q.phase == PH_CB &&
      st_q.line == LS_ACTIVE)
    else $error("pair consumed off the Cb slot");

  fill_word_a: assert property (                         // R6
    O_UNDERRUN |-> O_DATA_T == lanes(FILL_CHROMA, st_q.narrow))
    else $error("missing pair not replaced by filler");

endmodule : pcv_source

/* pcv_dest_model.sv */
/*
  Destination model: captures the word bus on each forwarded rising edge.
  Assumes complementary buses and a forwarded clock from the source.
*/
`timescale 1ns/10ps
module pcv_dest_model
  import pcv_pkg::*;
(
  input  wire logic      i_clk_t,
  input  wire pcv_word_t i_data_t,
  input  wire pcv_word_t i_data_c,
  output pcv_word_t      o_word,
  output int             o_cnt,
  output int             o_bad
);
  realtime   t_chg  = 0.0;
  logic      late;
  logic      skew;
  pcv_word_t word_q = '0;
  int        cnt_q  = 0;
  int        bad_q  = 0;
  // ==========================================================
  // Capture
  assign o_word = word_q;
  assign o_cnt  = cnt_q;
  assign o_bad  = bad_q;
  always @(i_data_t) t_chg = $realtime;
  always @(posedge i_clk_t)
  begin
    skew = (i_data_c !== ~i_data_t);
    // Real receivers need the word settled well before the edge
    late = ($realtime - t_chg) < 100.0;
    word_q <= i_data_t;
    cnt_q  <= cnt_q + 1;
    if (skew || late)
      bad_q <= bad_q + 1;
  end
endmodule : pcv_dest_model

/* tb.sv */
/*
  Bench for the component video source.
  Assumes the destination model counts each captured word.
*/
`timescale 1ns/10ps
module tb;
  import pcv_pkg::*;
  logic      clk, rst_n, lclk, nar, blank, pv, av, ct, cc;
  logic      ptake, atake, urun;
  pcv_pair_t pair;
  pcv_word_t anc, dt, dc, word;
  int        cnt, bad, error_cnt, checked, anc_cnt, pol_bad;
  // ==========================================================
  // Clocks, unrelated in phase
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #160 lclk = ~lclk;
  end
  // Pulse and polarity watchers, sampled away from the launching edge
  always @(negedge clk)
  begin
    if (atake === 1'b1) anc_cnt++;
    if (rst_n === 1'b1 && cc !== ~ct) pol_bad++;
  end
  pcv_source i_pcv_source (.I_CLK(clk), .I_RST_N(rst_n),
    .I_LINK_CLK(lclk), .I_NARROW(nar), .I_BLANK(blank), .I_PAIR(pair),
    .I_PAIR_VALID(pv), .I_ANC(anc), .I_ANC_VALID(av), .O_DATA_T(dt),
    .O_DATA_C(dc), .O_CLK_T(ct), .O_CLK_C(cc), .O_PAIR_TAKE(ptake),
    .O_ANC_TAKE(atake), .O_UNDERRUN(urun));
  pcv_dest_model i_pcv_dest_model (.i_clk_t(ct), .i_data_t(dt),
    .i_data_c(dc), .o_word(word), .o_cnt(cnt), .o_bad(bad));
  // ==========================================================
  // Shared tasks
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input pcv_word_t got, input pcv_word_t exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 400)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask : wait_hi
  // Waits for the next captured word and compares it when cmp is set
  task automatic get_word(input pcv_word_t exp, input logic cmp);
    int c0, n;
    c0 = cnt;
    n = 0;
    while (cnt == c0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
    begin
      error_cnt++;
      report_and_stop();
    end
    else if (cmp)
    begin
      chk(word, exp);
    end
  endtask : get_word
  // ==========================================================
  // Scenarios
  task automatic run_pair(input pcv_pair_t p, input logic n);
    pcv_word_t w[4];
    int        a0;
    w = '{p.cb, p.y0, p.cr, p.y1};
    blank = 1'b1;
    get_word('0, 1'b0);
    get_word('0, 1'b0);
    a0 = anc_cnt;
    {blank, pv, av, nar, pair} = {3'b011, n, p};
    wait_hi(ptake);
    {pv, av} = 2'b00;
    for (int i = 0; i < 4; i++)
      get_word(n ? {w[i][7:0], 2'h0} : w[i], 1'b1);
    chk(pcv_word_t'(anc_cnt - a0), '0);
  endtask : run_pair
  task automatic run_underrun;
    wait_hi(urun);
    get_word(FILL_CHROMA, 1'b1);
    get_word(FILL_LUMA, 1'b1);
  endtask : run_underrun
  task automatic run_anc(input pcv_word_t a, input logic n);
    int a0;
    a0 = anc_cnt;
    {blank, av, nar, anc} = {2'b11, n, a};
    wait_hi(atake);
    av = 1'b0;
    get_word(n ? {a[7:0], 2'h0} : a, 1'b1);
    chk(pcv_word_t'(anc_cnt - a0), 10'h001);
  endtask : run_anc
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, nar, blank, pv, av, pair, anc} = '0;
    repeat (5) @(negedge clk);
    chk(dt, WORD_RST);
    chk({dc[9:2], ct, cc}, 10'h3fd);
    rst_n = 1'b1;
    run_pair('{10'h3c1, 10'h0a5, 10'h25a, 10'h3fe}, 1'b0);
    run_underrun();
    run_pair('{10'h0c3, 10'h1ff, 10'h280, 10'h001}, 1'b1);
    run_anc(10'h2a5, 1'b1);
    run_anc(10'h15a, 1'b0);
    chk(pcv_word_t'(bad), '0);
    chk(pcv_word_t'(pol_bad), '0);
    report_and_stop();
  end
endmodule : tb
